// [rtl/ibe_pkg.sv]
// shared constants and types for the two-wire bus master host
package ibe_pkg;
  localparam int          CLK_NS  = 40;
  localparam int          QTR_NS  = 2500;
  localparam logic [15:0] DIV_RST = 16'(QTR_NS / CLK_NS - 1);
  localparam int          AXI_AW  = 4;

  localparam logic [AXI_AW-1:0] OFF_CMD  = 4'h0;
  localparam logic [AXI_AW-1:0] OFF_STAT = 4'h4;
  localparam logic [AXI_AW-1:0] OFF_RX   = 4'h8;
  localparam logic [AXI_AW-1:0] OFF_DIV  = 4'hC;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] ACK_BIT     = 4'h8;
  // a new input level is taken on the fifth tick in a row, so it lasted four periods
  localparam logic [2:0] DEB_SPAN    = 3'h4;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_DATA  = 5'h04,
    S_STOP  = 5'h08,
    S_HOLD  = 5'h10
  } ibe_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ibe_line_t;

  // command word, bit 12 down to bit 0
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rd;
    logic       wr;
    logic       nack;
    logic [7:0] data;
  } ibe_cmd_t;

  typedef struct packed {
    logic own;
    logic ack;
    logic arb;
    logic bus_busy;
    logic active;
  } ibe_status_t;
endpackage

// [rtl/ibe_pin_sync.sv]
// two-stage synchroniser for the bus line inputs
`timescale 1ns/1ps
module ibe_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ibe_pin_sync

// [rtl/ibe_tick_div.sv]
// divider giving a one-cycle enable every reload+1 clocks
`timescale 1ns/1ps
module ibe_tick_div #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] reload,
  output logic              tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  always_comb begin
    next_tick = (cnt == '0);
    next_cnt  = next_tick ? reload : cnt - W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // ibe_tick_div

// [rtl/ibe_host.sv]
// two-wire bus master host, controlled over AXI4-Lite
`timescale 1ns/1ps
// Overview of operation
// [R01] data changes only while clock is low
// [R02] start: data falls while clock high
// [R03] stop: data rises while clock high
// [R04] bus busy from start until stop
// [R05] repeated start keeps bus busy
// [R06] only the master forms start and stop
// [R07] eight data bits then one acknowledge bit
// [R08] most significant bit goes first
// [R09] master waits while slave holds clock low
// [R10] master clocks the ninth acknowledge pulse
// [R11] transmitter releases data during acknowledge
// [R12] receiver holds data low to acknowledge
// [R13] busy slave leaves acknowledge high
// [R14] missing acknowledge ends in stop or restart
// [R15] master receiver refuses last byte acknowledge
// [R16] clock falling edge restarts low count
// [R17] high count starts once clock is high
// [R18] begin as master only on free bus
// [R19] high driven but low read loses arbitration
// [R20] arbitrate every bit from address on
// [R21] debounce drops glitches under four ticks
// [R22] debounce prescaler set before enabling
// [R23] arbitration loss sets flag, then idle
// [R24] bus busy visible as status flag
// [R25] event holds clock low until status write; here the clock is held low until the next command write
// [R26] lines are only pulled low or released
module ibe_host (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [ibe_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [ibe_pkg::AXI_AW-1:0] araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire ibe_pkg::ibe_line_t       line_level,
  output ibe_pkg::ibe_line_t            line_drive,
  output ibe_pkg::ibe_line_t            line_release
);
  import ibe_pkg::*;

  ibe_line_t         line_sync;
  logic              scl_h;
  logic              sda_h;
  logic              tick;
  logic [15:0]       div;
  logic [15:0]       next_div;
  // register bus state
  logic              aw_got, next_aw_got, w_got, next_w_got;
  logic [AXI_AW-1:0] aw_q, next_aw_q;
  logic [31:0]       wd_q, next_wd_q;
  logic [3:0]        ws_q, next_ws_q;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              wr_go, wr_cmd, wr_clr, cmd_ok;
  ibe_status_t       status;
  // engine state
  ibe_state_t        st, next_st;
  logic [1:0]        ph, next_ph;
  logic [3:0]        bit_cnt, next_bit_cnt;
  logic [7:0]        shreg, next_shreg, rx_data, next_rx_data;
  ibe_cmd_t          cmd, next_cmd;
  logic              cmd_pend, next_cmd_pend, rx_ack, next_rx_ack;
  logic              arb_lost, next_arb_lost, bus_busy, next_bus_busy;
  logic              scl_rel, next_scl_rel, sda_rel, next_sda_rel;
  ibe_line_t         prev, next_prev;
  logic              start_det, stop_det, arb_evt, tx_msb;
  // debounce filter state
  logic              deb_en, next_deb_en, deb_tick;
  logic [7:0]        deb_pre, next_deb_pre;
  ibe_line_t         line_in, flt, next_flt;
  logic [2:0]        flt_scl_n, next_flt_scl_n, flt_sda_n, next_flt_sda_n;

  function automatic logic tx_release(ibe_cmd_t c, logic [7:0] s, logic [3:0] n);
    if (n == ACK_BIT) begin
      return c.rd ? c.nack : 1'b1;
    end
    return c.rd ? 1'b1 : s[7];
  endfunction

  // one filter step: returns the filtered level and the tick count
  function automatic logic [3:0] flt_step(logic raw, logic cur, logic [2:0] n, logic t);
    if (raw == cur) begin
      return {cur, 3'h0};
    end
    if (!t) begin
      return {cur, n};
    end
    if (n == DEB_SPAN) begin
      return {raw, 3'h0};
    end
    return {cur, n + 3'h1};
  endfunction

  ibe_pin_sync #(.W(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (line_level),
    .q       (line_sync)
  );

  ibe_tick_div #(.W(16)) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .reload  (div),
    .tick    (tick)
  );

  ibe_tick_div #(.W(8)) u_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .reload  (deb_pre),
    .tick    (deb_tick)
  );

  assign line_in      = deb_en ? flt : line_sync;
  assign scl_h        = line_in.scl;
  assign sda_h        = line_in.sda;
  assign tx_msb       = shreg[7];
  assign line_release = '{scl: scl_rel, sda: sda_rel};
  assign cmd_ok       = !cmd_pend && ((st == S_IDLE && wd_q[12]) || st == S_HOLD);

  always_comb begin
    status.own      = (st != S_IDLE);
    status.ack      = rx_ack;
    status.arb      = arb_lost;
    // [R24] bus busy flag
    status.bus_busy = bus_busy;
    status.active   = cmd_pend || !(st == S_IDLE || st == S_HOLD);
  end

  // register bus slave: write and address taken in either order
  always_comb begin
    next_aw_got  = aw_got | (awvalid & awready);
    next_aw_q    = (awvalid & awready) ? awaddr : aw_q;
    next_w_got   = w_got | (wvalid & wready);
    next_wd_q    = (wvalid & wready) ? wdata : wd_q;
    next_ws_q    = (wvalid & wready) ? wstrb : ws_q;
    next_bvalid  = bvalid & ~bready;
    next_bresp   = bresp;
    next_div     = div;
    next_deb_en  = deb_en;
    next_deb_pre = deb_pre;
    wr_go        = aw_got & w_got & ~bvalid;
    wr_cmd       = wr_go && aw_q == OFF_CMD && ws_q[1];
    wr_clr       = wr_go && aw_q == OFF_STAT && ws_q[0] && wd_q[2];
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bresp  = RESP_OKAY;
      if (aw_q == OFF_CMD) begin
        if (!cmd_ok) begin
          next_bresp = RESP_SLVERR;
        end
      end else if (aw_q == OFF_DIV) begin
        if (ws_q[0]) begin
          next_div[7:0] = wd_q[7:0];
        end
        if (ws_q[1]) begin
          next_div[15:8] = wd_q[15:8];
        end
        // [R22] prescaler taken only while the filter is off
        if (ws_q[2] && !deb_en) begin
          next_deb_pre = wd_q[23:16];
        end
        if (ws_q[3]) begin
          next_deb_en = wd_q[24];
        end
      end else if (aw_q != OFF_STAT && aw_q != OFF_RX) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready  = ~next_w_got & ~next_bvalid;
    next_rvalid  = rvalid & ~rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (araddr == OFF_CMD) begin
        next_rdata = {19'h0_0000, cmd};
      end else if (araddr == OFF_STAT) begin
        next_rdata = {27'h000_0000, status};
      end else if (araddr == OFF_RX) begin
        next_rdata = {24'h00_0000, rx_data};
      end else if (araddr == OFF_DIV) begin
        next_rdata = {7'h00, deb_en, deb_pre, div};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_q    <= '0;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      div     <= DIV_RST;
      deb_en  <= 1'b0;
      deb_pre <= 8'h00;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      aw_q    <= next_aw_q;
      wd_q    <= next_wd_q;
      ws_q    <= next_ws_q;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      div     <= next_div;
      deb_en  <= next_deb_en;
      deb_pre <= next_deb_pre;
    end
  end

  // [R21] [R22] filter runs on the prescaled tick; follows the pins when off
  always_comb begin
    {next_flt.scl, next_flt_scl_n} = flt_step(line_sync.scl, flt.scl, flt_scl_n, deb_tick);
    {next_flt.sda, next_flt_sda_n} = flt_step(line_sync.sda, flt.sda, flt_sda_n, deb_tick);
    if (!deb_en) begin
      next_flt       = line_sync;
      next_flt_scl_n = 3'h0;
      next_flt_sda_n = 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt       <= '1;
      flt_scl_n <= 3'h0;
      flt_sda_n <= 3'h0;
    end else begin
      flt       <= next_flt;
      flt_scl_n <= next_flt_scl_n;
      flt_sda_n <= next_flt_sda_n;
    end
  end

  // bus engine: four phases per bit, advanced on divider ticks; phase 1 lasts until the clock reads high
  always_comb begin
    next_st       = st;
    next_ph       = ph;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_rx_data  = rx_data;
    next_cmd      = cmd;
    next_cmd_pend = cmd_pend;
    next_rx_ack   = rx_ack;
    next_arb_lost = arb_lost;
    next_bus_busy = bus_busy;
    next_scl_rel  = scl_rel;
    next_sda_rel  = sda_rel;
    next_prev     = line_in;
    arb_evt       = 1'b0;
    start_det     = prev.scl && scl_h && prev.sda && !sda_h;
    stop_det      = prev.scl && scl_h && !prev.sda && sda_h;
    // [R04] [R05] busy from any start until a stop
    if (start_det) begin
      next_bus_busy = 1'b1;
    end else if (stop_det) begin
      next_bus_busy = 1'b0;
    end
    if (wr_clr) begin
      next_arb_lost = 1'b0;
    end
    if (wr_cmd && cmd_ok) begin
      next_cmd      = ibe_cmd_t'(wd_q[12:0]);
      next_cmd_pend = 1'b1;
    end
    case (st)
      S_IDLE: begin
        // [R18] claim the bus only while free
        if (cmd_pend && !bus_busy) begin
          next_st       = S_START;
          next_ph       = 2'h0;
          next_cmd_pend = 1'b0;
        end
      end
      S_HOLD: begin
        // [R25] clock held low until the next command write
        if (cmd_pend) begin
          next_cmd_pend = 1'b0;
          next_ph       = 2'h0;
          // [R14] after an answer, restart or stop on command
          if (cmd.start) begin
            next_st = S_START;
          end else if (cmd.rd || cmd.wr) begin
            next_st      = S_DATA;
            next_shreg   = cmd.data;
            next_bit_cnt = 4'h0;
          end else if (cmd.stop) begin
            next_st = S_STOP;
          end
        end
      end
      S_START: begin
        if (tick) begin
          case (ph)
            2'h0: begin
              next_sda_rel = 1'b1;
              next_ph      = 2'h1;
            end
            2'h1: begin
              next_scl_rel = 1'b1;
              if (scl_h) begin
                next_ph = 2'h2;
              end
            end
            2'h2: begin
              // [R02] [R06] data falls with clock high
              next_sda_rel = 1'b0;
              next_ph      = 2'h3;
            end
            default: begin
              next_scl_rel = 1'b0;
              next_ph      = 2'h0;
              next_bit_cnt = 4'h0;
              next_shreg   = cmd.data;
              next_st      = (cmd.rd || cmd.wr) ? S_DATA : S_HOLD;
            end
          endcase
        end
      end
      S_DATA: begin
        if (tick) begin
          case (ph)
            2'h0: begin
              // [R01] [R08] [R11] [R12] [R15] data set while clock low
              next_sda_rel = tx_release(cmd, shreg, bit_cnt);
              next_ph      = 2'h1;
            end
            2'h1: begin
              // [R09] [R16] [R17] wait until the line is really high
              next_scl_rel = 1'b1;
              if (scl_h) begin
                next_ph = 2'h2;
              end
            end
            2'h2: begin
              next_ph = 2'h3;
              if (bit_cnt != ACK_BIT) begin
                next_shreg = {shreg[6:0], sda_h};
                // [R19] [R20] [R23] lost: flag, release, go idle
                if (!cmd.rd && sda_rel && !sda_h) begin
                  arb_evt       = 1'b1;
                  next_arb_lost = 1'b1;
                  next_scl_rel  = 1'b1;
                  next_ph       = 2'h0;
                  next_st       = S_IDLE;
                end
              end else begin
                // [R13] a high acknowledge reads as refused
                next_rx_ack  = !sda_h;
                next_rx_data = shreg;
              end
            end
            default: begin
              next_scl_rel = 1'b0;
              next_ph      = 2'h0;
              // [R07] [R10] ninth pulse closes the byte
              if (bit_cnt == ACK_BIT) begin
                next_bit_cnt = 4'h0;
                next_st      = cmd.stop ? S_STOP : S_HOLD;
              end else begin
                next_bit_cnt = bit_cnt + 4'h1;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (tick) begin
          case (ph)
            2'h0: begin
              next_sda_rel = 1'b0;
              next_ph      = 2'h1;
            end
            2'h1: begin
              next_scl_rel = 1'b1;
              if (scl_h) begin
                next_ph = 2'h2;
              end
            end
            2'h2: begin
              // [R03] data rises with clock high
              next_sda_rel = 1'b1;
              next_ph      = 2'h3;
            end
            default: begin
              next_ph = 2'h0;
              next_st = S_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= S_IDLE;
      ph         <= 2'h0;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      rx_data    <= 8'h00;
      cmd        <= '0;
      cmd_pend   <= 1'b0;
      rx_ack     <= 1'b0;
      arb_lost   <= 1'b0;
      bus_busy   <= 1'b0;
      scl_rel    <= 1'b1;
      sda_rel    <= 1'b1;
      prev       <= '1;
      line_drive <= '0;
    end else begin
      st         <= next_st;
      ph         <= next_ph;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      rx_data    <= next_rx_data;
      cmd        <= next_cmd;
      cmd_pend   <= next_cmd_pend;
      rx_ack     <= next_rx_ack;
      arb_lost   <= next_arb_lost;
      bus_busy   <= next_bus_busy;
      scl_rel    <= next_scl_rel;
      sda_rel    <= next_sda_rel;
      prev       <= next_prev;
      // [R26] lines are never driven high
      line_drive <= '0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sda_steady: assert property ( // [R01]
    st == S_DATA && scl_rel && $past(scl_rel) && scl_h |-> $stable(sda_rel))
    else $error("data line moved while clock high");
  chk_start_shape: assert property ( // [R02]
    $fell(sda_rel) && $past(st) == S_START |-> $past(scl_rel) && $past(scl_h))
    else $error("start formed with clock low");
  chk_stop_shape: assert property ( // [R03]
    $rose(sda_rel) && $past(st) == S_STOP |-> $past(scl_rel) && $past(scl_h))
    else $error("stop formed with clock low");
  chk_busy_track: assert property ( // [R04]
    start_det |=> bus_busy ##1 (bus_busy || stop_det || $past(stop_det)))
    else $error("bus busy not raised by start");
  chk_byte_ninth: assert property ( // [R07]
    $past(st) == S_DATA && st != S_DATA && st != S_IDLE |-> $past(bit_cnt) == ACK_BIT)
    else $error("byte left before ninth bit");
  chk_msb_first: assert property ( // [R08]
    st == S_DATA && tick && ph == 2'h0 && bit_cnt == 4'h0 && !cmd.rd
    |=> sda_rel == $past(tx_msb))
    else $error("first bit is not the msb");
  chk_stretch_wait: assert property ( // [R09]
    st != S_IDLE && ph == 2'h1 && !scl_h |=> ph == 2'h1)
    else $error("phase advanced while clock held low");
  chk_ack_free: assert property ( // [R11]
    st == S_DATA && !cmd.rd && bit_cnt == ACK_BIT && ph != 2'h0 |-> sda_rel)
    else $error("data not released for acknowledge");
  chk_ack_hold: assert property ( // [R12]
    st == S_DATA && cmd.rd && !cmd.nack && bit_cnt == ACK_BIT && ph != 2'h0 |-> !sda_rel)
    else $error("acknowledge not held low");
  chk_nack_last: assert property ( // [R15]
    st == S_DATA && cmd.rd && cmd.nack && bit_cnt == ACK_BIT && ph != 2'h0 |-> sda_rel)
    else $error("last byte acknowledged");
  chk_arb_drop: assert property ( // [R19]
    arb_evt |=> sda_rel && scl_rel && st == S_IDLE && arb_lost)
    else $error("lost arbitration without release");

  cov_start_byte: cover property (st == S_START ##1 st == S_DATA);
  cov_read_byte: cover property (st == S_DATA && cmd.rd ##1 st == S_HOLD);
  cov_arb_loss: cover property (arb_evt);
  cov_stretch: cover property ((st == S_DATA && ph == 2'h1 && !scl_h)[*3]);
endmodule // ibe_host

// [tb/ibe_slave_model.sv]
// behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module ibe_slave_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] stretch_ns,
  input  wire logic        nack_data,
  input  wire logic [15:0] tx_word,
  output logic             scl_rel,
  output logic             sda_rel,
  output logic [7:0]       rx_byte,
  output int               n_start,
  output int               n_stop
);
  int         bitn;
  logic [7:0] sh;
  logic       adr, sel, rdm, txo, mack, nt;

  initial begin
    bitn = -2;
    {scl_rel, sda_rel, sel, txo} = 4'b1100;
    n_start = 0;
    n_stop = 0;
    rx_byte = 8'h00;
  end

  // start or repeated start restarts the address phase
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      bitn = -1;
      {adr, sel, txo, sda_rel} = 4'b1001;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stop++;
      bitn = -2;
      {sel, txo} = 2'b00;
    end
  end

  // eight bits sampled msb first while the clock is high
  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8) mack = !sda;
  end

  // data moves only after the clock falls
  always @(negedge scl) begin
    if (bitn == 8) begin
      bitn = 0;
      txo = adr ? (sel && rdm) : (txo && mack);
      nt = !adr;
      adr = 1'b0;
      sda_rel = txo ? tx_word[nt ? 7 : 15] : 1'b1;
      // hold the clock low between bytes while not ready
      if (stretch_ns != 0 && sel) begin
        scl_rel = 1'b0;
        #(stretch_ns);
        scl_rel = 1'b1;
      end
    end else if (bitn >= -1) begin
      bitn++;
      if (bitn < 8) begin
        sda_rel = txo ? tx_word[(nt ? 7 : 15) - bitn] : 1'b1;
      end else if (txo) begin
        sda_rel = 1'b1;
      end else if (adr) begin
        sel = sh[7:1] == ADDR;
        rdm = sh[0];
        sda_rel = !sel;
      end else if (sel) begin
        rx_byte = sh;
        sda_rel = nack_data;
      end
    end
  end
endmodule // ibe_slave_model

// [tb/ibe_host_tb.sv]
// self-checking bench for the two-wire bus master host
`timescale 1ns/1ps
`define CHK(gv, xv) begin \
  n_tests++; \
  if ((gv) !== (xv)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: got %0h, expected %0h", $time, gv, xv); \
  end \
end
module ibe_host_tb;
  import ibe_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, nack_data, oth, s_scl, s_sda;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, got, rnd;
  logic [1:0]  bresp, rresp;
  logic [15:0] stretch, tx_word;
  logic [7:0]  rx_byte;
  logic [33:0] q[$];
  logic [33:0] e;
  ibe_line_t   lvl, drv, rel;
  int          n_start, n_stop, n_mismatch, n_tests, k, j;
  bit          peek;
  wire         scl_w = rel.scl & s_scl;
  wire         sda_w = rel.sda & s_sda & oth;

  assign lvl = {scl_w, sda_w};

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  ibe_host dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_level(lvl),
    .line_drive(drv), .line_release(rel)
  );

  ibe_slave_model slv (
    .scl(scl_w), .sda(sda_w), .stretch_ns(stretch), .nack_data(nack_data), .tx_word(tx_word),
    .scl_rel(s_scl), .sda_rel(s_sda), .rx_byte(rx_byte), .n_start(n_start), .n_stop(n_stop)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // responses are matched against the oldest expectation
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready && !peek)) begin
      e = q.pop_front();
      `CHK(bvalid ? {bresp, 32'h0000_0000} : {rresp, rdata}, e)
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tw;
    q.push_back({r, 32'h0000_0000});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wready && !tw) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input bit chk);
    if (chk) q.push_back({RESP_OKAY, d});
    @(posedge aclk);
    peek = !chk;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    got = rdata;
    rready <= 1'b0;
  endtask

  // polls status until the engine has nothing in hand
  task automatic idle;
    for (int i = 0; i < 300; i++) begin
      rd(OFF_STAT, 32'h0000_0000, 0);
      if (got[0] === 1'b0) return;
    end
    n_mismatch++;
  endtask

  task automatic note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, nack_data} = 6'h00;
    {awaddr, araddr, wdata} = 40'h00_0000_0000;
    wstrb = 4'hF;
    oth = 1'b1;
    stretch = 16'h0000;
    tx_word = 16'h0000;
    rnd = 32'h2dcd_a6c0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STAT, 32'h0000_0000, 1);
    rd(OFF_DIV, {16'h0000, DIV_RST}, 1);
    wr(OFF_DIV, 32'h0000_0003, RESP_OKAY);
    rd(OFF_DIV, 32'h0000_0003, 1);
    wr(OFF_CMD, 32'h0000_0255, RESP_SLVERR);
    note("setup");
    k = n_start;
    wr(OFF_CMD, 32'h0000_12A4, RESP_OKAY);
    idle;
    rd(OFF_STAT, 32'h0000_001A, 1);
    `CHK(n_start, k + 1)
    note("address");
    rnd = lfsr(rnd);
    stretch = 16'd2000;
    wr(OFF_CMD, {24'h00_0002, rnd[7:0]}, RESP_OKAY);
    idle;
    stretch = 16'h0000;
    `CHK(rx_byte, rnd[7:0])
    rd(OFF_STAT, 32'h0000_001A, 1);
    rnd = lfsr(rnd);
    nack_data = 1'b1;
    k = n_stop;
    wr(OFF_CMD, {24'h00_000A, rnd[7:0]}, RESP_OKAY);
    idle;
    nack_data = 1'b0;
    `CHK(rx_byte, rnd[7:0])
    rd(OFF_RX, {24'h00_0000, rnd[7:0]}, 1);
    rd(OFF_STAT, 32'h0000_0000, 1);
    `CHK(n_stop, k + 1)
    note("stretch and refusal");
    wr(OFF_CMD, 32'h0000_12FF, RESP_OKAY);
    @(negedge scl_w);
    @(posedge aclk);
    oth <= 1'b0;
    idle;
    rd(OFF_STAT, 32'h0000_0006, 1);
    `CHK(rel, 2'b11)
    @(posedge aclk);
    oth <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0004, 1);
    wr(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0000, 1);
    note("arbitration");
    rnd = lfsr(rnd);
    tx_word = rnd[15:0];
    wr(OFF_CMD, 32'h0000_12A4, RESP_OKAY);
    idle;
    k = n_stop;
    j = n_start;
    wr(OFF_CMD, 32'h0000_12A5, RESP_OKAY);
    idle;
    rd(OFF_STAT, 32'h0000_001A, 1);
    `CHK(n_start - j + n_stop - k, 1)
    wr(OFF_CMD, 32'h0000_0400, RESP_OKAY);
    idle;
    rd(OFF_RX, {24'h00_0000, tx_word[15:8]}, 1);
    rd(OFF_STAT, 32'h0000_001A, 1);
    wr(OFF_CMD, 32'h0000_0D00, RESP_OKAY);
    idle;
    rd(OFF_RX, {24'h00_0000, tx_word[7:0]}, 1);
    rd(OFF_STAT, 32'h0000_0000, 1);
    note("master read");
    @(posedge aclk);
    oth <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0002, 1);
    wr(OFF_CMD, 32'h0000_12A4, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0003, 1);
    @(posedge aclk);
    oth <= 1'b1;
    idle;
    rd(OFF_STAT, 32'h0000_001A, 1);
    wr(OFF_CMD, 32'h0000_0A55, RESP_OKAY);
    idle;
    `CHK(rx_byte, 8'h55)
    rd(OFF_STAT, 32'h0000_0008, 1);
    `CHK(drv, 2'b00)
    note("busy bus");
    wr(OFF_DIV, 32'h010F_0003, RESP_OKAY);
    wr(OFF_DIV, 32'h0100_0003, RESP_OKAY);
    rd(OFF_DIV, 32'h010F_0003, 1);
    @(posedge aclk);
    oth <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0008, 1);
    oth <= 1'b1;
    wr(OFF_DIV, 32'h0000_0003, RESP_OKAY);
    note("debounce");
    results();
  end
endmodule // ibe_host_tb
